// File: inc/fbc_params.svh
// constants for the boot and logic-array configuration control
// What this block does
// (RL1) after reset, copy flash bootstrap to address zero
// (RL2) bootstrap order: defaults, configure, link loader, run
// (RL3) loader locks onto first active port only
// (RL4) ports report not ready until array configured
// (RL5) outsiders wait about two seconds after reset; nothing here times it, FBC_SETTLE_CYCLES is unused
// (RL6) write to third select clears the array
// (RL7) fourth select writes clock configuration bits serially
// (RL8) poll status until configured, then continue loading
// (RL9) flash 16-bit; boot copy uses low byte
// (RL10) four 2MB pages chosen by gpio 9, 10
// (RL11) page change touches only gpio bits 9, 10
// (RL12) flash page decoded on second select, first processor
// (RL13) first processor sees two sdram banks, others one
// (RL14) status not configured while clearing or programming
`ifndef FBC_PARAMS_SVH
`define FBC_PARAMS_SVH

`define FBC_CLK_NS 50
`define FBC_FLASH_BASE 32'h6400_0000
`define FBC_CLEAR_BASE 32'h6800_0000
`define FBC_PROG_BASE 32'h6c00_0000
`define FBC_SDRAM0_BASE 32'h8000_0000
`define FBC_SDRAM1_BASE 32'h9000_0000
`define FBC_REGION_MASK 32'hfc00_0000
`define FBC_FLASH_MASK 32'hffe0_0000
`define FBC_PAGE_LO 9
`define FBC_PAGE_HI 10
`define FBC_STATUS_DONE_BIT 0
`define FBC_GPIO_RESET 16'h0000
`define FBC_CLEAR_NS 500
`define FBC_CLEAR_CYCLES ((`FBC_CLEAR_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_CONFIG_SERIAL_CLOCK_HALF_NS 100
`define FBC_CONFIG_SERIAL_CLOCK_DIV (`FBC_CONFIG_SERIAL_CLOCK_HALF_NS / `FBC_CLK_NS)
`define FBC_CFG_BITS 16
`define FBC_BOOT_BYTES 64
`define FBC_CFG_PAGE 2'h1
`define FBC_CFG_WORDS 16
`define FBC_SETTLE_S 2
`define FBC_SETTLE_CYCLES (`FBC_SETTLE_S * (1000000000 / `FBC_CLK_NS))

`endif

// File: inc/fbc_pkg.sv
// types shared by both ends of the boot control
`include "fbc_params.svh"
package fbc_pkg;
    typedef enum {FBC_RG_NONE, FBC_RG_FLASH, FBC_RG_CLEAR, FBC_RG_PROG,
                  FBC_RG_SDRAM0, FBC_RG_SDRAM1} fbc_region_type;
    typedef enum {FBC_D_IDLE, FBC_D_FLASH, FBC_D_CLEAR, FBC_D_SHIFT,
                  FBC_D_ACK} fbc_dev_state_type;
    typedef enum {FBC_P_COPY, FBC_P_CLEAR, FBC_P_PAGE, FBC_P_PROG, FBC_P_POLL,
                  FBC_P_LOADER, FBC_P_RUN} fbc_proc_state_type;

    // maps a processor address onto the board region it selects
    function automatic fbc_region_type fbc_region(input logic [31:0] addr,
                                                  input logic first_proc);
        fbc_region_type r;
        r = FBC_RG_NONE;
        if ((addr & `FBC_FLASH_MASK) == `FBC_FLASH_BASE && first_proc) begin
            r = FBC_RG_FLASH;
        end else if ((addr & `FBC_REGION_MASK) == `FBC_CLEAR_BASE && first_proc) begin
            r = FBC_RG_CLEAR;
        end else if ((addr & `FBC_REGION_MASK) == `FBC_PROG_BASE && first_proc) begin
            r = FBC_RG_PROG;
        end else if ((addr & `FBC_REGION_MASK) == `FBC_SDRAM0_BASE) begin
            r = FBC_RG_SDRAM0;
        end else if ((addr & `FBC_REGION_MASK) == `FBC_SDRAM1_BASE && first_proc) begin
            r = FBC_RG_SDRAM1;
        end
        return r;
    endfunction
endpackage

// File: inc/fbc_if.sv
// memory-port link between the processor end and the board end
`timescale 1ns/1ns
`default_nettype none
interface fbc_if;
    logic req; // one-cycle access request
    logic we; // request is a write
    logic [31:0] addr; // byte address
    logic [15:0] wdata; // write data
    logic [15:0] rdata; // read data, valid with ack
    logic ack; // one-cycle completion
    logic boot_copy; // processor internal boot copy active
    logic [15:0] gpio; // processor general-purpose lines
    logic comm_ready; // communication ports may transfer

    modport dev (input req, we, addr, wdata, boot_copy, gpio,
                 output rdata, ack, comm_ready);
    modport proc (output req, we, addr, wdata, boot_copy, gpio,
                  input rdata, ack, comm_ready);
endinterface
`default_nettype wire

// File: design/fbc_board.sv
// board end: memory-port decode, flash paging, array clear and serial load
`timescale 1ns/1ns
`default_nettype none
module fbc_board
    import fbc_pkg::*;
#(
    parameter bit FIRST_PROC = 1'b1
) (
    input wire logic ref_clk, // 20 MHz clock
    input wire logic reset, // asynchronous, active high
    fbc_if.dev bus, // memory port from the processor
    output logic [21:0] flash_addr, // flash word address
    output logic flash_rd, // flash read strobe
    input wire logic [15:0] flash_rdata, // flash data, sampled in the strobe cycle
    output logic config_clear, // clears the array, active high
    output logic config_serial_clock, // serial configuration clock
    output logic config_data, // serial configuration data
    input wire logic config_done, // array reports configured
    output logic [1:0] sdram_sel, // sdram bank selects
    output logic configured // array configured and idle
);
    fbc_dev_state_type st_q, st_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] sh_q, sh_d;
    logic [4:0] bit_q, bit_d;
    logic config_serial_clock_q, config_serial_clock_d;
    logic cdata_q, cdata_d;
    logic clear_q, clear_d;
    logic ack_q, ack_d;
    logic [15:0] rdata_q, rdata_d;
    logic rd_q, rd_d;
    logic [21:0] faddr_q, faddr_d;
    logic [1:0] sel_q, sel_d;
    logic cfg_q, cfg_d;
    logic copy_q, copy_d;
    logic tick;
    fbc_region_type rg;

    // divider pulse paces the serial clock
    // the divider restarts with every new word
    assign tick = (cnt_q == 16'(`FBC_CONFIG_SERIAL_CLOCK_DIV - 1));
    assign rg = fbc_region(bus.addr, FIRST_PROC);

    // next-state logic of the access engine
    // a request is taken only while idle; the far end waits for the
    // answer before the next one, so nothing needs queueing here
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        bit_d = bit_q;
        config_serial_clock_d = config_serial_clock_q;
        cdata_d = cdata_q;
        clear_d = 1'b0;
        ack_d = 1'b0;
        rdata_d = rdata_q;
        rd_d = 1'b0;
        faddr_d = faddr_q;
        sel_d = 2'b00;
        copy_d = copy_q;
        case (st_q)
            FBC_D_IDLE: begin
                if (bus.req) begin
                    rdata_d = 16'h0000;
                    cnt_d = 16'h0000;
                    case (rg)
                        FBC_RG_FLASH: begin
                            // page bits from gpio 9, 10 extend the 20 address lines
                            faddr_d = {bus.gpio[`FBC_PAGE_HI], bus.gpio[`FBC_PAGE_LO],
                                       bus.addr[20:1]}; // [RL10] [RL12]
                            rd_d = ~bus.we;
                            copy_d = bus.boot_copy;
                            st_d = bus.we ? FBC_D_ACK : FBC_D_FLASH;
                        end
                        FBC_RG_CLEAR: begin
                            if (bus.we) begin
                                clear_d = 1'b1; // [RL6]
                                st_d = FBC_D_CLEAR;
                            end else begin
                                st_d = FBC_D_ACK;
                            end
                        end
                        FBC_RG_PROG: begin
                            if (bus.we) begin
                                // each write sends its word msb first
                                sh_d = bus.wdata; // [RL7]
                                cdata_d = bus.wdata[15];
                                bit_d = 5'h00;
                                st_d = FBC_D_SHIFT;
                            end else begin
                                rdata_d[`FBC_STATUS_DONE_BIT] = cfg_q; // [RL8]
                                st_d = FBC_D_ACK;
                            end
                        end
                        FBC_RG_SDRAM0: begin
                            sel_d = 2'b01; // [RL13]
                            st_d = FBC_D_ACK;
                        end
                        FBC_RG_SDRAM1: begin
                            sel_d = 2'b10; // [RL13]
                            st_d = FBC_D_ACK;
                        end
                        default: begin
                            st_d = FBC_D_ACK;
                        end
                    endcase
                end
            end
            // flash data is taken in the same cycle as the read strobe
            FBC_D_FLASH: begin
                // boot copy sees only the low byte of the 16-bit flash
                rdata_d = copy_q ? {8'h00, flash_rdata[7:0]} : flash_rdata; // [RL9]
                st_d = FBC_D_ACK;
            end
            // the answer waits for the whole clear pulse, so loading
            // cannot start on a half-erased array
            FBC_D_CLEAR: begin
                clear_d = 1'b1; // [RL6]
                cnt_d = cnt_q + 16'h0001;
                if (cnt_q == 16'(`FBC_CLEAR_CYCLES - 1)) begin
                    clear_d = 1'b0;
                    st_d = FBC_D_ACK;
                end
            end
            // data moves only while the serial clock is low, so each
            // rising edge samples a settled bit
            FBC_D_SHIFT: begin
                cnt_d = tick ? 16'h0000 : cnt_q + 16'h0001;
                if (tick) begin
                    if (!config_serial_clock_q) begin
                        config_serial_clock_d = 1'b1; // [RL7]
                    end else begin
                        config_serial_clock_d = 1'b0;
                        sh_d = {sh_q[14:0], 1'b0};
                        cdata_d = sh_q[14];
                        bit_d = bit_q + 5'h01;
                        if (bit_q == 5'(`FBC_CFG_BITS - 1)) begin
                            st_d = FBC_D_ACK;
                        end
                    end
                end
            end
            FBC_D_ACK: begin
                ack_d = 1'b1;
                copy_d = 1'b0;
                st_d = FBC_D_IDLE;
            end
            default: begin
                st_d = FBC_D_IDLE;
            end
        endcase
    end

    // status shows configured only when done and no clear or load is running
    // done may still stand from an earlier load while a new one runs;
    // masking it keeps the ports not ready only while a clear, a word shift or a flash read runs, not between words
    always_comb begin
        cfg_d = config_done && (st_d == FBC_D_IDLE || st_d == FBC_D_ACK) &&
                (st_q != FBC_D_CLEAR) && (st_q != FBC_D_SHIFT); // [RL14]
    end

    // registers of the access engine
    // reset leaves the ports not ready until config_done is seen with the engine idle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_q <= FBC_D_IDLE;
            cnt_q <= 16'h0000;
            sh_q <= 16'h0000;
            bit_q <= 5'h00;
            config_serial_clock_q <= 1'b0;
            cdata_q <= 1'b0;
            clear_q <= 1'b0;
            ack_q <= 1'b0;
            rdata_q <= 16'h0000;
            rd_q <= 1'b0;
            faddr_q <= 22'h000000;
            sel_q <= 2'b00;
            cfg_q <= 1'b0;
            copy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            config_serial_clock_q <= config_serial_clock_d;
            cdata_q <= cdata_d;
            clear_q <= clear_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            rd_q <= rd_d;
            faddr_q <= faddr_d;
            sel_q <= sel_d;
            cfg_q <= cfg_d;
            copy_q <= copy_d;
        end
    end

    // outputs straight from flip-flops
    assign bus.ack = ack_q;
    assign bus.rdata = rdata_q;
    assign bus.comm_ready = cfg_q; // [RL4]
    assign flash_addr = faddr_q;
    assign flash_rd = rd_q;
    assign config_clear = clear_q;
    assign config_serial_clock = config_serial_clock_q;
    assign config_data = cdata_q;
    assign sdram_sel = sel_q;
    assign configured = cfg_q;
endmodule
`default_nettype wire

// File: design/fbc_proc.sv
// processor end: boot copy, array clear and load, status poll, port loader
`timescale 1ns/1ns
`default_nettype none
module fbc_proc
    import fbc_pkg::*;
(
    input wire logic ref_clk, // 20 MHz clock
    input wire logic reset, // board reset, asynchronous, active high
    fbc_if.proc bus, // memory port to the board
    input wire logic [3:0] comm_valid, // data present per port
    input wire logic [3:0][7:0] comm_data, // data per port
    output logic [7:0] load_data, // byte taken from the locked port
    output logic load_strobe, // one-cycle pulse per byte taken
    output logic [1:0] load_port, // locked port number
    output logic [7:0] boot_byte0, // first byte of the copied bootstrap
    output logic running // control handed to the loaded program
);
    fbc_proc_state_type st_q, st_d;
    logic req_q, req_d, we_q, we_d, wait_q, wait_d, ph_q, ph_d;
    logic [31:0] addr_q, addr_d;
    logic [15:0] wdata_q, wdata_d, gpio_q, gpio_d, idx_q, idx_d;
    logic [7:0] boot_mem [0:`FBC_BOOT_BYTES-1];
    logic lock_q, lock_d, strobe_q, strobe_d, run_q, run_d;
    logic [1:0] port_q, port_d;
    logic [7:0] data_q, data_d;
    logic [1:0] first_port;

    // lowest numbered port with data
    always_comb begin
        first_port = 2'd0;
        for (int i = 3; i >= 0; i--) begin
            if (comm_valid[i]) begin
                first_port = 2'(i);
            end
        end
    end

    // boot sequence: copy, clear, page, program, poll, loader
    always_comb begin
        st_d = st_q;
        req_d = 1'b0;
        we_d = we_q;
        wait_d = wait_q;
        ph_d = ph_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        gpio_d = gpio_q;
        idx_d = idx_q;
        lock_d = lock_q;
        strobe_d = 1'b0;
        run_d = run_q;
        port_d = port_q;
        data_d = data_q;
        if (wait_q && bus.ack) begin
            wait_d = 1'b0;
        end
        case (st_q)
            FBC_P_COPY: begin
                if (!wait_q) begin
                    req_d = 1'b1; // [RL1]
                    we_d = 1'b0;
                    wait_d = 1'b1;
                    addr_d = `FBC_FLASH_BASE + {15'h0000, idx_q, 1'b0};
                end else if (bus.ack) begin
                    idx_d = idx_q + 16'h0001;
                    if (idx_q == 16'(`FBC_BOOT_BYTES - 1)) begin
                        idx_d = 16'h0000;
                        st_d = FBC_P_CLEAR; // [RL2]
                    end
                end
            end
            FBC_P_CLEAR: begin
                if (!wait_q) begin
                    req_d = 1'b1; // [RL6]
                    we_d = 1'b1;
                    wait_d = 1'b1;
                    addr_d = `FBC_CLEAR_BASE;
                end else if (bus.ack) begin
                    st_d = FBC_P_PAGE;
                end
            end
            FBC_P_PAGE: begin
                gpio_d[`FBC_PAGE_HI:`FBC_PAGE_LO] = `FBC_CFG_PAGE; // [RL11]
                st_d = FBC_P_PROG;
            end
            FBC_P_PROG: begin
                if (!wait_q) begin
                    req_d = 1'b1;
                    we_d = ph_q; // [RL7]
                    wait_d = 1'b1;
                    addr_d = ph_q ? `FBC_PROG_BASE :
                             `FBC_FLASH_BASE + {15'h0000, idx_q, 1'b0};
                end else if (bus.ack) begin
                    ph_d = ~ph_q;
                    wdata_d = bus.rdata;
                    if (ph_q) begin
                        idx_d = idx_q + 16'h0001;
                        if (idx_q == 16'(`FBC_CFG_WORDS - 1)) begin
                            st_d = FBC_P_POLL;
                        end
                    end
                end
            end
            FBC_P_POLL: begin
                if (!wait_q) begin
                    req_d = 1'b1; // [RL8]
                    we_d = 1'b0;
                    wait_d = 1'b1;
                    addr_d = `FBC_PROG_BASE;
                end else if (bus.ack && bus.rdata[`FBC_STATUS_DONE_BIT]) begin
                    st_d = FBC_P_LOADER;
                end
            end
            FBC_P_LOADER: begin
                // lock onto the first port that shows data, ignore the rest
                if (bus.comm_ready && !lock_q && comm_valid != 4'h0) begin
                    lock_d = 1'b1; // [RL3]
                    port_d = first_port;
                end else if (lock_q && comm_valid[port_q]) begin
                    data_d = comm_data[port_q]; // [RL3]
                    strobe_d = 1'b1;
                    st_d = FBC_P_RUN;
                end
            end
            FBC_P_RUN: begin
                run_d = 1'b1; // [RL2]
                if (comm_valid[port_q]) begin
                    data_d = comm_data[port_q];
                    strobe_d = 1'b1;
                end
            end
            default: begin
                st_d = FBC_P_COPY;
            end
        endcase
    end

    // registers of the boot sequence
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_q <= FBC_P_COPY;
            req_q <= 1'b0;
            we_q <= 1'b0;
            wait_q <= 1'b0;
            ph_q <= 1'b0;
            addr_q <= 32'h0000_0000;
            wdata_q <= 16'h0000;
            gpio_q <= `FBC_GPIO_RESET;
            idx_q <= 16'h0000;
            lock_q <= 1'b0;
            strobe_q <= 1'b0;
            run_q <= 1'b0;
            port_q <= 2'd0;
            data_q <= 8'h00;
        end else begin
            st_q <= st_d;
            req_q <= req_d;
            we_q <= we_d;
            wait_q <= wait_d;
            ph_q <= ph_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            gpio_q <= gpio_d;
            idx_q <= idx_d;
            lock_q <= lock_d;
            strobe_q <= strobe_d;
            run_q <= run_d;
            port_q <= port_d;
            data_q <= data_d;
        end
    end

    // bootstrap lands in internal memory from address zero
    always_ff @(posedge ref_clk) begin
        if (st_q == FBC_P_COPY && wait_q && bus.ack) begin
            boot_mem[idx_q[5:0]] <= bus.rdata[7:0]; // [RL1]
        end
    end

    assign bus.req = req_q;
    assign bus.we = we_q;
    assign bus.addr = addr_q;
    assign bus.wdata = wdata_q;
    assign bus.gpio = gpio_q;
    assign bus.boot_copy = (st_q == FBC_P_COPY);
    assign load_data = data_q;
    assign load_strobe = strobe_q;
    assign load_port = port_q;
    assign boot_byte0 = boot_mem[0];
    assign running = run_q;
endmodule
`default_nettype wire

// File: verification/fbc_checker.sv
// assertions on the memory-port link between processor and board ends
`timescale 1ns/1ns
`default_nettype none
`include "fbc_params.svh"
module fbc_checker (
    input wire logic ref_clk, // link clock
    input wire logic reset, // asynchronous, active high
    input wire logic req, // access request
    input wire logic we, // write flag
    input wire logic [31:0] addr, // byte address
    input wire logic [15:0] wdata, // write data
    input wire logic [15:0] rdata, // read data
    input wire logic ack, // completion
    input wire logic boot_copy, // boot copy active
    input wire logic [15:0] gpio, // processor gpio
    input wire logic comm_ready // ports may transfer
);
    logic rd_flash;
    logic wr_clear;
    logic wr_prog;
    logic rd_status;
    // decode of the request on the link
    assign rd_flash = req && !we && ((addr & `FBC_FLASH_MASK) == `FBC_FLASH_BASE);
    assign wr_clear = req && we && ((addr & `FBC_REGION_MASK) == `FBC_CLEAR_BASE);
    assign wr_prog = req && we && ((addr & `FBC_REGION_MASK) == `FBC_PROG_BASE);
    assign rd_status = req && !we && ((addr & `FBC_REGION_MASK) == `FBC_PROG_BASE);

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    AST_FIRST_FETCH: assert property ($fell(reset) |-> ##[0:2] (req && addr == `FBC_FLASH_BASE))
        else $error("first fetch after reset is not from flash start");
    AST_BOOT_LOW_BYTE: assert property (ack && boot_copy |-> rdata[15:8] == 8'h00)
        else $error("boot copy returned upper byte");
    AST_FLASH_ANSWER: assert property (rd_flash |-> ##3 ack)
        else $error("flash read not answered in three cycles");
    AST_CLEAR_HOLDS: assert property (wr_clear |-> ##1 (!ack)[*8] ##[3:6] ack)
        else $error("clear write answered too early or too late");
    AST_PROG_SERIAL_LEN: assert property (wr_prog |-> ##1 (!ack)[*8] ##[40:80] ack)
        else $error("program write did not take the serial time");
    AST_STATUS_ANSWER: assert property (rd_status |-> ##2 ack)
        else $error("status read not answered in two cycles");
    AST_NOT_READY_IN_COPY: assert property (boot_copy |-> !comm_ready)
        else $error("ports ready during boot copy");
    AST_ACK_PULSE: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    AST_ONE_OUTSTANDING: assert property (req |=> (!req)[*2])
        else $error("request issued with one outstanding");
    AST_GPIO_PAGE_ONLY: assert property ($changed(gpio) |-> (gpio & 16'hf9ff) == ($past(gpio) & 16'hf9ff))
        else $error("gpio change touched bits outside the page");
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// bench joining processor and board ends, plus a board driven by bench tasks
`timescale 1ns/1ns
`default_nettype none
`include "fbc_params.svh"
module tb_top;
    import fbc_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    int fail_count = 0;
    int cmp_count = 0;
    int bits1 = 0;
    int bitcnt2 = 0;
    int clrcnt2 = 0;
    int strobes = 0;
    int bad_strobes = 0;
    logic [21:0] fa1, fa2;
    logic [15:0] fd1, fd2, shift2, q;
    logic clr1, clr2, sck1, sck2, sd2, done1, cfg1, cfg2;
    logic done2 = 1'b1;
    logic [1:0] sel2;
    logic [1:0] sel_seen = 2'h0;
    logic [3:0] comm_valid;
    logic [3:0][7:0] comm_data;
    logic [7:0] load_data, boot_byte0;
    logic load_strobe, running;
    logic [1:0] load_port;
    fbc_if link_bus();
    fbc_if tb_bus();

    fbc_proc fbc_proc_inst (.ref_clk(ref_clk), .reset(reset), .bus(link_bus.proc),
        .comm_valid(comm_valid), .comm_data(comm_data), .load_data(load_data),
        .load_strobe(load_strobe), .load_port(load_port), .boot_byte0(boot_byte0),
        .running(running));
    fbc_board fbc_board_inst (.ref_clk(ref_clk), .reset(reset), .bus(link_bus.dev),
        .flash_addr(fa1), .flash_rd(), .flash_rdata(fd1), .config_clear(clr1),
        .config_serial_clock(sck1), .config_data(), .config_done(done1), .sdram_sel(),
        .configured(cfg1));
    fbc_board fbc_board_inst_b (.ref_clk(ref_clk), .reset(reset), .bus(tb_bus.dev),
        .flash_addr(fa2), .flash_rd(), .flash_rdata(fd2), .config_clear(clr2),
        .config_serial_clock(sck2), .config_data(sd2), .config_done(done2),
        .sdram_sel(sel2), .configured(cfg2));
    fbc_checker fbc_checker_inst (.ref_clk(ref_clk), .reset(reset), .req(link_bus.req),
        .we(link_bus.we), .addr(link_bus.addr), .wdata(link_bus.wdata),
        .rdata(link_bus.rdata), .ack(link_bus.ack), .boot_copy(link_bus.boot_copy),
        .gpio(link_bus.gpio), .comm_ready(link_bus.comm_ready));

    // flash content: a pattern that differs per word and per page
    function automatic logic [15:0] flash_word(input logic [21:0] wa);
        return wa[15:0] + {wa[21:20], 14'h0a5c};
    endfunction
    assign fd1 = flash_word(fa1);
    assign fd2 = flash_word(fa2);

    // array models: cleared by the clear line; the first is done after a full bit stream, the second when the bench sets done2
    always @(posedge sck1) bits1 <= bits1 + 1;
    always @(posedge clr1) bits1 <= 0;
    assign done1 = (bits1 >= `FBC_CFG_WORDS * `FBC_CFG_BITS) && !clr1;
    always @(posedge clr2) done2 <= 1'b0;
    always @(posedge sck2) begin
        shift2 <= {shift2[14:0], sd2};
        bitcnt2 <= bitcnt2 + 1;
    end
    // monitors for clear length, bank selects and loader strobes
    always @(posedge ref_clk) begin
        if (clr2 === 1'b1) clrcnt2 <= clrcnt2 + 1;
        if (sel2 != 2'h0) sel_seen <= sel_seen | sel2;
        if (load_strobe === 1'b1) begin
            strobes <= strobes + 1;
            if (load_port !== 2'h2 || load_data !== 8'h5a) bad_strobes <= bad_strobes + 1;
        end
    end

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one access on the bench-driven port: pulse req, hold the rest until ack
    task automatic access(input logic w, input logic [31:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        tb_bus.req <= 1'b1;
        tb_bus.we <= w;
        tb_bus.addr <= a;
        tb_bus.wdata <= d;
        @(posedge ref_clk);
        tb_bus.req <= 1'b0;
        while (tb_bus.ack !== 1'b1 && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
        q = tb_bus.rdata;
        if (n >= 200) check("ack", 32'h1, 32'h0);
        @(posedge ref_clk);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        check("watchdog", 32'h0, 32'h1);
        summarize();
    end

    initial begin
        logic [21:0] wa;
        int n;
        tb_bus.req = 1'b0;
        tb_bus.we = 1'b0;
        tb_bus.addr = 32'h0;
        tb_bus.wdata = 16'h0;
        tb_bus.boot_copy = 1'b0;
        tb_bus.gpio = 16'h0;
        comm_valid = 4'h0;
        comm_data = '0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        // paging: page from gpio 10:9 only, word address from addr 20:1
        for (int p = 0; p < 4; p++) begin
            tb_bus.gpio <= 16'ha000 | (16'(p) << 9);
            access(1'b0, 32'h6401_2346, 16'h0);
            wa = {p[1:0], 20'h091a3};
            check("flash_addr", 32'(wa), 32'(fa2));
            check("flash_data", 32'(flash_word(wa)), 32'(q));
        end
        tb_bus.boot_copy <= 1'b1;
        tb_bus.gpio <= 16'h0;
        access(1'b0, 32'h6400_0010, 16'h0);
        check("boot_data", {24'h0, 8'(flash_word(22'h8))}, 32'(q));
        tb_bus.boot_copy <= 1'b0;
        $display("test paging done");
        // clear, program and status in sequence
        access(1'b0, 32'h6c00_0000, 16'h0);
        check("status_before", 32'h1, 32'(q[0]));
        clrcnt2 = 0;
        access(1'b1, 32'h6800_0000, 16'h0);
        check("clear_len", `FBC_CLEAR_CYCLES, clrcnt2);
        access(1'b0, 32'h6c00_0000, 16'h0);
        check("status_cleared", 32'h0, 32'(q[0]));
        bitcnt2 = 0;
        access(1'b1, 32'h6c00_0000, 16'hb38d);
        check("serial_bits", 32'd16, bitcnt2);
        check("serial_data", 32'hb38d, 32'(shift2));
        access(1'b0, 32'h6c00_0000, 16'h0);
        check("status_prog", 32'h0, 32'(q[0]));
        done2 <= 1'b1;
        access(1'b0, 32'h6c00_0000, 16'h0);
        check("status_done", 32'h3, 32'({q[0], cfg2}));
        $display("test configure done");
        // sdram banks and unmapped places
        sel_seen = 2'h0;
        access(1'b0, 32'h8000_0040, 16'h0);
        check("bank0_sel", 32'h1, 32'(sel_seen));
        sel_seen = 2'h0;
        access(1'b0, 32'h9000_0040, 16'h0);
        check("bank1_sel", 32'h2, 32'(sel_seen));
        access(1'b0, 32'h7000_0000, 16'h0);
        check("unmapped", 32'h0, 32'(q));
        access(1'b0, 32'h6800_0000, 16'h0);
        check("clear_read", 32'h0, 32'(q));
        $display("test decode done");
        // paired ends boot on their own, then the loader locks on port 2
        n = 0;
        while (link_bus.comm_ready !== 1'b1 && n < 8000) begin
            @(posedge ref_clk);
            n++;
        end
        check("ports_ready", 32'h1, 32'(link_bus.comm_ready));
        check("boot_byte0", {24'h0, 8'(flash_word(22'h0))}, 32'(boot_byte0));
        comm_data <= {8'h00, 8'h5a, 8'h00, 8'hee};
        comm_valid <= 4'b0100;
        repeat (20) @(posedge ref_clk);
        comm_valid <= 4'b0101;
        repeat (20) @(posedge ref_clk);
        comm_valid <= 4'b0000;
        repeat (2) @(posedge ref_clk);
        check("strobes_seen", 32'h1, 32'(strobes > 0));
        check("foreign_strobes", 32'h0, bad_strobes);
        check("running", 32'h1, 32'(running));
        $display("test boot done");
        summarize();
    end
endmodule
`default_nettype wire
